// ===== hdl/codec_control_regs.sv
// Purpose: decode serial control words into codec control registers zero and one
// Assumes: word_valid_i is a one-cycle strobe from the serial receiver on sys_clk_i
// Notes:   sys_clk_i is the input clock; derived clocks are register outputs
//
// Function
// - accepted 16-bit word goes to register picked by top two bits; protocol ignored.
// - select 00 loads register zero, 01 loads register one.
// - codec stays inactive until active bit set; clearing powers it down.
// - four-bit gain code gives attenuation in 3 dB steps, 1111 is 0 dB.
// - reset leaves gain code 0000 and test, active, mute, range, select clear.
// - mute bit clear suppresses analog output, set passes it.
// - range bit clear selects 500 mVp, set selects 160 mVp.
// - input select clear picks microphone, set picks auxiliary input.
// - adjust direction clear retards internal clock, set advances it at divide by two only; resets clear.
// - adjust amount n shifts internal clock one input cycle for n cycles.
// - prescaler clear gives internal clock divide by one, set by two; resets set.
// - first divider code zero disables the first output clock.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_cfg.svh"

module codec_control_regs
  import codec_ctrl_pkg::*;
#(
  parameter int DIV_W = 5,
  parameter int ADJ_W = 7
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // control word from the serial receiver
  input  wire logic             word_valid_i,
  input  wire logic [15:0]      word_i,
  // register zero controls
  output logic                  loopback_test_o,
  output logic                  codec_active_o,
  output logic [3:0]            output_gain_field_o,
  output logic [5:0]            output_atten_db_o,
  output logic                  analog_out_pass_o,
  output logic                  mic_range_bit_o,
  output logic                  input_select_bit_o,
  // register one controls
  output logic                  phase_adjust_direction_o,
  output logic [ADJ_W-1:0]      phase_adjust_amount_o,
  output logic                  internal_prescaler_bit_o,
  output logic                  phase_adjust_busy_o,
  // derived clocks
  output logic                  internal_clock_o,
  output logic                  first_output_clock_o,
  output logic                  second_output_clock_o
);

  // ----------------------------------------
  // control word decode
  // ----------------------------------------
  ctrl_body_t ctrl_zero;
  ctrl_body_t ctrl_one;
  ctrl_body_t next_ctrl_zero;
  ctrl_body_t next_ctrl_one;
  logic       write_zero;
  logic       write_one;

  // selects 10 and 11 belong to registers outside this bank
  assign write_zero = word_valid_i
                    && (word_i[`CCR_SEL_HI:`CCR_SEL_LO] == `CCR_SEL_ZERO);
  assign write_one  = word_valid_i
                    && (word_i[`CCR_SEL_HI:`CCR_SEL_LO] == `CCR_SEL_ONE);

  // the 14-bit body lands whole; the fields are picked apart below
  always_comb begin
    next_ctrl_zero = ctrl_zero;
    next_ctrl_one  = ctrl_one;
    if (write_zero) begin
      next_ctrl_zero = word_i[13:0];
    end
    if (write_one) begin
      next_ctrl_one = word_i[13:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_zero <= `CCR0_RESET;
      ctrl_one  <= `CCR1_RESET;
    end else begin
      ctrl_zero <= next_ctrl_zero;
      ctrl_one  <= next_ctrl_one;
    end
  end

  // ----------------------------------------
  // register zero fields
  // ----------------------------------------
  logic [3:0] gain_code;

  assign gain_code = ctrl_zero[`CCR0_GAIN_HI:`CCR0_GAIN_LO];

  // powered down is the reset state, so the codec stays inactive until software opts in; the internal and first output clocks run from reset
  // the mute bit is a pass bit: clear means silent
  always_comb begin
    loopback_test_o     = ctrl_zero[`CCR0_TEST_BIT];
    codec_active_o      = ctrl_zero[`CCR0_ACTIVE_BIT];
    output_gain_field_o = gain_code;
    analog_out_pass_o   = ctrl_zero[`CCR0_MUTE_BIT];
    mic_range_bit_o     = ctrl_zero[`CCR0_RANGE_BIT];
    input_select_bit_o  = ctrl_zero[`CCR0_INPUT_SELECT_BIT_BIT];
  end

  // ----------------------------------------
  // register one fields
  // ----------------------------------------
  logic [ADJ_W-1:0] adj_amount;

  assign adj_amount = ctrl_one[`CCR1_ADJ_HI:`CCR1_ADJ_LO];

  // any register one write restarts the adjust run, even one meant only for a divider; a write with amount zero ends it
  always_comb begin
    phase_adjust_direction_o = ctrl_one[`CCR1_DIR_BIT];
    phase_adjust_amount_o    = adj_amount;
    internal_prescaler_bit_o = ctrl_one[`CCR1_PRE_BIT];
  end

  // ----------------------------------------
  // output attenuation
  // ----------------------------------------
  // attenuation in dB, positive number: 0 at code 1111, 45 at code 0000
  // registered to keep the multiply off the output path; it lags the gain by one cycle
  logic [3:0] gain_steps;
  logic [5:0] next_atten_db;

  assign gain_steps    = `GAIN_MAX_CODE - gain_code;
  assign next_atten_db = 6'(gain_steps) * `GAIN_STEP_DB;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_atten_db_o <= `ATTEN_RESET_DB;
    end else begin
      output_atten_db_o <= next_atten_db;
    end
  end

  // ----------------------------------------
  // phase adjust sequencer
  // ----------------------------------------
  adj_state_t       adj_state;
  adj_state_t       next_adj_state;
  logic [ADJ_W-1:0] adj_left;
  logic [ADJ_W-1:0] next_adj_left;
  logic             ick_tick;

  // the run counts internal ticks, so its length in input cycles follows the prescaler
  always_comb begin
    next_adj_state = adj_state;
    next_adj_left  = adj_left;
    case (adj_state)
      adj_idle: begin
        next_adj_left = '0;
      end
      adj_busy: begin
        if (ick_tick) begin
          next_adj_left = adj_left - 1'b1;
          if (adj_left == ADJ_W'(1)) begin
            next_adj_state = adj_idle;
          end
        end
      end
      default: begin
        next_adj_state = adj_idle;
        next_adj_left  = '0;
      end
    endcase
    // a new write restarts the run and wins over the count running out
    if (write_one) begin
      next_adj_left  = word_i[`CCR1_ADJ_HI:`CCR1_ADJ_LO];
      next_adj_state = (word_i[`CCR1_ADJ_HI:`CCR1_ADJ_LO] == '0)
                     ? adj_idle : adj_busy;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adj_state <= adj_idle;
      adj_left  <= '0;
    end else begin
      adj_state <= next_adj_state;
      adj_left  <= next_adj_left;
    end
  end

  // straight from the state flop, so busy carries no decode glitch
  assign phase_adjust_busy_o = (adj_state == adj_busy);

  // ----------------------------------------
  // internal clock
  // ----------------------------------------
  logic [1:0] ick_base;
  logic [1:0] ick_period;
  logic [1:0] ick_cnt;
  logic [1:0] next_ick_cnt;
  logic       next_ick_level;

  // at divide by one the level stays high outside a retard run; the edges are those of the input clock
  always_comb begin
    ick_base = ctrl_one[`CCR1_PRE_BIT]
             ? `ICK_PERIOD_DIV2 : `ICK_PERIOD_DIV1;
    ick_period = ick_base;
    if (adj_state == adj_busy) begin
      if (!ctrl_one[`CCR1_DIR_BIT]) begin
        ick_period = ick_base + 2'h1;
      end else if (ick_base > 2'h1) begin
        // at divide by one a period cannot shrink further, so advance is lost
        ick_period = ick_base - 2'h1;
      end
    end
    ick_tick       = (ick_cnt >= ick_period - 2'h1);
    next_ick_cnt   = ick_tick ? 2'h0 : ick_cnt + 2'h1;
    next_ick_level = (next_ick_cnt == 2'h0);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ick_cnt          <= 2'h0;
      internal_clock_o <= 1'b0;
    end else begin
      ick_cnt          <= next_ick_cnt;
      internal_clock_o <= next_ick_level;
    end
  end

  // ----------------------------------------
  // output clock dividers
  // ----------------------------------------
  // index 0: first clock from internal clock ticks
  // index 1: second clock from every input clock edge
  logic [DIV_W-1:0] div_code [2];
  logic             src_tick [2];
  logic             div_out  [2];

  assign div_code[0] = ctrl_one[`CCR1_DIV_HI:`CCR1_DIV_LO];
  assign div_code[1] = ctrl_zero[`CCR0_DIV_HI:`CCR0_DIV_LO];
  assign src_tick[0] = ick_tick;
  assign src_tick[1] = 1'b1;

  // ----------------------------------------
  // divider loop
  // ----------------------------------------
  // index 1 sees a tick on every edge, so its code 1 gives a steady high
  for (genvar g = 0; g < 2; g++) begin : gen_div
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic [DIV_W-1:0] live_code;
    logic [DIV_W-1:0] next_live_code;
    logic             next_out;
    logic [DIV_W:0]   half;

    // a nonzero code written mid-period waits for the wrap; code zero drives the pin low at once
    always_comb begin
      // high for the first half of n source periods, rounded up
      half           = (DIV_W+1)'({1'b0, live_code} + 1'b1) >> 1;
      next_cnt       = cnt;
      next_out       = div_out[g];
      next_live_code = live_code;
      if (div_code[g] == '0) begin
        next_cnt       = '0;
        next_out       = 1'b0;
        next_live_code = '0;
      end else if (live_code == '0) begin
        // restart from a stopped divider with the counter at zero
        next_live_code = div_code[g];
      end else if (src_tick[g]) begin
        if (cnt >= live_code - 1'b1) begin
          next_cnt       = '0;
          next_live_code = div_code[g];
        end else begin
          next_cnt = cnt + 1'b1;
        end
        next_out = ({1'b0, next_cnt} < half);
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt        <= '0;
        live_code  <= '0;
        div_out[g] <= 1'b0;
      end else begin
        cnt        <= next_cnt;
        live_code  <= next_live_code;
        div_out[g] <= next_out;
      end
    end
  end

  assign first_output_clock_o  = div_out[0];
  assign second_output_clock_o = div_out[1];

endmodule : codec_control_regs

`default_nettype wire

// ===== hdl/codec_ctrl_cfg.svh
// Purpose: offsets, field positions, reset values of codec control words
// Assumes: 16-bit control words, select in the top two bits
// Notes:   definitions only
`ifndef CODEC_CTRL_CFG_SVH
`define CODEC_CTRL_CFG_SVH

// ----------------------------------------
// register select codes
// ----------------------------------------
`define CCR_SEL_HI      15
`define CCR_SEL_LO      14
`define CCR_SEL_ZERO    2'h0
`define CCR_SEL_ONE     2'h1

// ----------------------------------------
// register zero fields
// ----------------------------------------
`define CCR0_TEST_BIT   13
`define CCR0_ACTIVE_BIT 12
`define CCR0_GAIN_HI    11
`define CCR0_GAIN_LO    8
`define CCR0_MUTE_BIT   7
`define CCR0_RANGE_BIT  6
`define CCR0_INPUT_SELECT_BIT_BIT  5
`define CCR0_DIV_HI     4
`define CCR0_DIV_LO     0
`define CCR0_RESET      14'h0000

// ----------------------------------------
// register one fields
// ----------------------------------------
`define CCR1_DIR_BIT    13
`define CCR1_ADJ_HI     12
`define CCR1_ADJ_LO     6
`define CCR1_PRE_BIT    5
`define CCR1_DIV_HI     4
`define CCR1_DIV_LO     0
`define CCR1_RESET      14'h0030

// ----------------------------------------
// gain and internal clock figures
// ----------------------------------------
`define GAIN_MAX_CODE   4'hf
`define GAIN_STEP_DB    6'h03
`define ICK_PERIOD_DIV1 2'h1
`define ICK_PERIOD_DIV2 2'h2
`define ATTEN_RESET_DB  6'h2d

`endif

// ===== hdl/codec_ctrl_pkg.sv
// Purpose: shared types for the codec control register bank
// Assumes: nothing beyond the config header
// Notes:   numbers live in codec_ctrl_cfg.svh
package codec_ctrl_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [13:0] ctrl_body_t;

  typedef enum logic {
    adj_idle,
    adj_busy
  } adj_state_t;

endpackage : codec_ctrl_pkg

// ===== bench/ctrl_word_writer.sv
// Purpose: processor side that writes control words
// Assumes: send and idle are called from one process
// Notes:   idle word lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module ctrl_word_writer (
  // clock
  input  wire logic        sys_clk_i,
  // word to the bank
  output var  logic        word_valid_o,
  output var  logic [15:0] word_o
);
  initial begin
    word_valid_o = 1'b0;
    word_o       = 16'h0000;
  end
  // caller puts the select code in the top two bits
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk_i);
    word_valid_o <= 1'b1;
    word_o       <= w;
  endtask : send
  // no stale word left on the lines
  task automatic idle;
    @(posedge sys_clk_i);
    word_valid_o <= 1'b0;
    word_o       <= ~word_o;
  endtask : idle
endmodule : ctrl_word_writer
`default_nettype wire

// ===== bench/codec_control_regs_sva.sv
// Purpose: port checks of the codec control bank
// Assumes: one clock, async low reset
// Notes:   bound after the module
`timescale 1ns/1ps
`default_nettype none
module codec_control_regs_sva #(
  parameter int DIV_W = 5,
  parameter int ADJ_W = 7
) (
  // inputs of the bank
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  input wire logic             word_valid_i,
  input wire logic [15:0]      word_i,
  // outputs of the bank
  input wire logic             loopback_test_o,
  input wire logic             codec_active_o,
  input wire logic [3:0]       output_gain_field_o,
  input wire logic [5:0]       output_atten_db_o,
  input wire logic             analog_out_pass_o,
  input wire logic             mic_range_bit_o,
  input wire logic             input_select_bit_o,
  input wire logic             phase_adjust_direction_o,
  input wire logic [ADJ_W-1:0] phase_adjust_amount_o,
  input wire logic             internal_prescaler_bit_o,
  input wire logic             phase_adjust_busy_o,
  input wire logic             internal_clock_o,
  input wire logic             first_output_clock_o,
  input wire logic             second_output_clock_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [8:0]       reg0_f = {loopback_test_o, codec_active_o, output_gain_field_o, analog_out_pass_o,
                                   mic_range_bit_o, input_select_bit_o};
  wire logic [ADJ_W+1:0] reg1_f = {phase_adjust_direction_o, phase_adjust_amount_o, internal_prescaler_bit_o};
  sequence s_wr0; word_valid_i && word_i[15:14] == 2'h0; endsequence
  sequence s_wr1; word_valid_i && word_i[15:14] == 2'h1; endsequence
  sequence s_quiet; (!word_valid_i)[*3]; endsequence
  a_reg0_load: assert property (s_wr0 |=> reg0_f == $past(word_i[13:5]))
    else $error("reg zero fields differ from word");
  a_reg1_load: assert property (s_wr1 |=> reg1_f == $past(word_i[13:5]))
    else $error("reg one fields differ from word");
  a_upper_ignored: assert property (word_valid_i && word_i[15] |=> $stable({reg0_f, reg1_f}))
    else $error("upper select changed a register");
  a_atten_steps: assert property (output_atten_db_o == 6'd45 - 6'd3 * $past(output_gain_field_o))
    else $error("attenuation not three dB per code");
  a_reset_state: assert property (!$past(rst_n_i) |-> reg0_f == 9'h000 && reg1_f == 9'h001)
    else $error("reset values wrong");
  a_second_off: assert property (s_wr0 ##0 word_i[4:0] == 5'h00 ##1 s_quiet |-> !second_output_clock_o)
    else $error("second clock runs at code zero");
  a_first_off: assert property (s_wr1 ##0 word_i[4:0] == 5'h00 ##1 s_quiet |-> !first_output_clock_o)
    else $error("first clock runs at code zero");
  a_busy_start: assert property (s_wr1 ##0 word_i[12:6] != 7'h00 |=> phase_adjust_busy_o)
    else $error("adjust run did not start");
  a_half_rate: assert property ((internal_prescaler_bit_o && !phase_adjust_busy_o)[*4] ##0 internal_clock_o
    |=> !internal_clock_o) else $error("internal clock not halved");
endmodule : codec_control_regs_sva
bind codec_control_regs codec_control_regs_sva #(.DIV_W(DIV_W), .ADJ_W(ADJ_W)) u_sva (.*);
`default_nettype wire

// ===== bench/codec_control_regs_tb_top.sv
// Purpose: self-checking bench of the codec control bank
// Assumes: words reach the bank through the writer model
// Notes:   reset first, then table, adjust runs, clock rates, reset
`timescale 1ns/1ps
`default_nettype none
module codec_control_regs_tb_top;
  import codec_ctrl_pkg::*;
  typedef struct {logic [15:0] w; logic [8:0] z; logic [8:0] o; logic [5:0] at;} row_t;
  logic        sys_clk_i, rst_n_i, word_valid_i, loopback_test_o, codec_active_o, analog_out_pass_o;
  logic        mic_range_bit_o, input_select_bit_o, phase_adjust_direction_o, internal_prescaler_bit_o;
  logic        phase_adjust_busy_o, internal_clock_o, first_output_clock_o, second_output_clock_o;
  logic [15:0] word_i;
  logic [3:0]  output_gain_field_o;
  logic [5:0]  output_atten_db_o;
  logic [6:0]  phase_adjust_amount_o;
  int          fails, n_checks, h1, h2;
  wire logic [8:0] reg0_v = {loopback_test_o, codec_active_o, output_gain_field_o, analog_out_pass_o,
                             mic_range_bit_o, input_select_bit_o};
  wire logic [8:0] reg1_v = {phase_adjust_direction_o, phase_adjust_amount_o, internal_prescaler_bit_o};
  // upper selects leave both registers alone
  row_t rows [8] = '{'{16'h1f80, 9'h0fc, 9'h001, 6'h00}, '{16'h2061, 9'h103, 9'h001, 6'h2d},
                     '{16'h8e00, 9'h103, 9'h001, 6'h2d}, '{16'h0e80, 9'h074, 9'h001, 6'h03},
                     '{16'h7fdf, 9'h074, 9'h1fe, 6'h03}, '{16'hc000, 9'h074, 9'h1fe, 6'h03},
                     '{16'h4020, 9'h074, 9'h001, 6'h03}, '{16'h0100, 9'h008, 9'h001, 6'h2a}};
  codec_control_regs uut (.*);
  ctrl_word_writer wr (.sys_clk_i(sys_clk_i), .word_valid_o(word_valid_i), .word_o(word_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic do_reset;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    tick();
    check("reg0", 16'h0000, 16'(reg0_v));
    check("reg1", 16'h0001, 16'(reg1_v));
    check("atten", 16'h002d, 16'(output_atten_db_o));
    $display("reset test done");
  endtask : do_reset
  // retard stretches each tick by one input cycle, advance shortens it at divide by two only
  task automatic run(input logic [15:0] w, input int lo, input int hi);
    int c;
    c = 0;
    wr.send(w);
    wr.idle();
    tick();
    check("busy", 16'h1, 16'(phase_adjust_busy_o));
    while (phase_adjust_busy_o === 1'b1 && c < 1000) begin
      tick();
      c++;
    end
    if (c < 1000) begin
      check("run length", 16'h1, 16'(c >= lo && c <= hi));
      $display("adjust test done");
    end else begin
      fails++;
      $display("Error run length expected %0d to %0d seen %0d", lo, hi, c);
      summarize();
    end
  endtask : run
  initial begin
    rst_n_i = 1'b0;
    fails = 0;
    n_checks = 0;
    do_reset();
    foreach (rows[i]) begin
      wr.send(rows[i].w);
      wr.idle();
      repeat (2) tick();
      check("reg0", 16'(rows[i].z), 16'(reg0_v));
      check("reg1", 16'(rows[i].o), 16'(reg1_v));
      check("atten", 16'(rows[i].at), 16'(output_atten_db_o));
    end
    $display("table test done");
    wr.send(16'h1000);
    run(16'h5fe1, 375, 390);
    check("active", 16'h1, 16'(codec_active_o));
    run(16'h7fe1, 122, 132);
    for (int k = 0; k < 2; k++) begin
      wr.send(k ? 16'h1000 : 16'h1002);
      wr.send(k ? 16'h4020 : 16'h4022);
      wr.idle();
      repeat (40) tick();
      h1 = 0;
      h2 = 0;
      repeat (40) begin
        tick();
        h1 += first_output_clock_o;
        h2 += second_output_clock_o;
      end
      check("first clock highs", k ? 16'h0 : 16'h14, 16'(h1));
      check("second clock highs", k ? 16'h0 : 16'h14, 16'(h2));
      $display("clock test done");
    end
    do_reset();
    // reset leaves the first clock at internal clock / 16 and the second one off
    h1 = 0;
    h2 = 0;
    repeat (8) tick();
    repeat (64) begin
      tick();
      h1 += first_output_clock_o;
      h2 += second_output_clock_o;
    end
    check("first clock reset highs", 16'h20, 16'(h1));
    check("second clock reset highs", 16'h0, 16'(h2));
    $display("reset clock test done");
    summarize();
  end
endmodule : codec_control_regs_tb_top
`default_nettype wire
